//--- shared/sesg_pkg.sv
// Shared constants and types of the standard event status group
package sesg_pkg;

  // ------------------------------------------------------------
  // Event register layout
  // ------------------------------------------------------------
  localparam int EVT_W = 16;
  localparam int BIT_OPC = 0;        // Operation complete
  localparam int BIT_REQ_CTRL = 1;   // Request control
  localparam int BIT_QRY_ERR = 2;    // Query error
  localparam int BIT_DEV_ERR = 3;    // Device dependent error
  localparam int BIT_EXE_ERR = 4;    // Execution error
  localparam int BIT_CMD_ERR = 5;    // Command error
  localparam int BIT_USER_REQ = 6;   // User request, never set
  localparam int BIT_PWR_ON = 7;     // Power on
  localparam int RSVD_LO = 8;        // First reserved bit
  localparam int RSVD_HI = 15;       // Last reserved bit

  // ------------------------------------------------------------
  // Reset values and limits
  // ------------------------------------------------------------
  localparam logic [15:0] EVT_RST = 16'h0080;  // Power on seen
  localparam logic [7:0] ESE_RST = 8'h00;
  localparam logic signed [15:0] ESE_MAX = 16'sh00FF;
  localparam logic signed [15:0] ERR_DATA_RANGE = -16'sd222;
  localparam logic signed [15:0] ERR_NONE = 16'sh0000;

  // ------------------------------------------------------------
  // Response characters
  // ------------------------------------------------------------
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_LF = 8'h0A;

  // ------------------------------------------------------------
  // Common commands decoded upstream
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_ESR_Q = 3'h1,
    CMD_CLS = 3'h2,
    CMD_ESE_W = 3'h3,
    CMD_ESE_Q = 3'h4,
    CMD_OPC = 3'h5
  } sesg_cmd_e;

  // Formatter states
  typedef enum logic [2:0] {
    FMT_IDLE = 3'b001,
    FMT_DIG = 3'b010,
    FMT_TERM = 3'b100
  } sesg_fmt_e;

endpackage

//--- logic/sesg_dec_fmt.sv
// Byte to decimal ASCII text formatter for query responses
`timescale 1ns/1ps
module sesg_dec_fmt (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [7:0] i_value,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_char,
  output logic o_last,
  output logic o_busy
);
  import sesg_pkg::*;

  sesg_fmt_e state_q, state_d;
  logic [7:0] value_q, value_d;
  logic [1:0] pos_q, pos_d;
  logic [7:0] char_q, char_d;
  logic last_q, last_d;
  logic valid_q, valid_d;

  // Decimal digit of a byte at position 0, 1 or 2, as ASCII
  function automatic logic [7:0] dig(input logic [7:0] v,
                                     input logic [1:0] p);
    logic [7:0] d;
    d = 8'h00;
    if (p == 2'h2) begin
      d = v / 8'd100;
    end else if (p == 2'h1) begin
      d = (v / 8'd10) % 8'd10;
    end else begin
      d = v % 8'd10;
    end
    return ASCII_ZERO + d;
  endfunction

  // ------------------------------------------------------------
  // Next state: digits, most significant first, then a line feed
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    value_d = value_q;
    pos_d = pos_q;
    char_d = char_q;
    last_d = last_q;
    case (state_q)
      FMT_IDLE: begin
        if (i_start) begin
          // Leading zeros are suppressed, zero itself prints one digit
          value_d = i_value;
          if (i_value >= 8'd100) begin
            pos_d = 2'h2;
          end else if (i_value >= 8'd10) begin
            pos_d = 2'h1;
          end else begin
            pos_d = 2'h0;
          end
          char_d = dig(i_value, pos_d);
          last_d = 1'b0;
          state_d = FMT_DIG;
        end
      end
      FMT_DIG: begin
        if (i_ready) begin
          if (pos_q == 2'h0) begin
            char_d = ASCII_LF;
            last_d = 1'b1;
            state_d = FMT_TERM;
          end else begin
            pos_d = pos_q - 2'h1;
            char_d = dig(value_q, pos_d);
          end
        end
      end
      FMT_TERM: begin
        if (i_ready) begin
          last_d = 1'b0;
          state_d = FMT_IDLE;
        end
      end
      default: begin
        state_d = FMT_IDLE;
      end
    endcase
    // Valid is registered so the top can pass it out straight from a flop
    valid_d = (state_d != FMT_IDLE);
  end

  // Registers only
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= FMT_IDLE;
      value_q <= 8'h00;
      pos_q <= 2'h0;
      char_q <= 8'h00;
      last_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      value_q <= value_d;
      pos_q <= pos_d;
      char_q <= char_d;
      last_q <= last_d;
      valid_q <= valid_d;
    end
  end

  assign o_valid = valid_q;
  assign o_busy = valid_q;
  assign o_char = char_q;
  assign o_last = last_q;

endmodule

//--- logic/sesg_top.sv
// Standard event status register group with enable mask and summary
`timescale 1ns/1ps
module sesg_top (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire sesg_pkg::sesg_cmd_e i_cmd,
  input wire logic signed [15:0] i_cmd_arg,
  input wire logic i_cmd_err,
  input wire logic i_exe_err,
  input wire logic i_dev_err,
  input wire logic i_qry_err,
  input wire logic i_req_ctrl,
  input wire logic i_ops_idle,
  input wire logic i_resp_ready,
  output logic o_cmd_ready,
  output logic o_resp_valid,
  output logic [7:0] o_resp_char,
  output logic o_resp_last,
  output logic [15:0] o_event,
  output logic [7:0] o_ese_mask,
  output logic o_esb_summary,
  output logic o_range_err,
  output logic signed [15:0] o_err_code
);
  import sesg_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [15:0] evt_q, evt_d;
  logic [7:0] ese_q, ese_d;
  logic opc_arm_q, opc_arm_d;
  logic ready_q, ready_d;
  logic sum_q, sum_d;
  logic rerr_q, rerr_d;
  logic signed [15:0] ecode_q, ecode_d;

  logic take, esr_rd, cls, ese_wr, ese_rd, opc_cmd;
  logic ese_bad, opc_fire, clr_evt;
  logic [15:0] set_v;
  logic fmt_start;
  logic [7:0] fmt_value;
  logic fmt_busy;

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  // Commands are taken only while the formatter is free, so a query
  // can never overwrite a response still being sent
  assign take = i_cmd_valid & ready_q;
  assign esr_rd = take & (i_cmd == CMD_ESR_Q);
  assign cls = take & (i_cmd == CMD_CLS);
  assign ese_wr = take & (i_cmd == CMD_ESE_W);
  assign ese_rd = take & (i_cmd == CMD_ESE_Q);
  assign opc_cmd = take & (i_cmd == CMD_OPC);
  assign ese_bad = (i_cmd_arg < 16'sh0000) | (i_cmd_arg > ESE_MAX);
  assign opc_fire = opc_arm_q & i_ops_idle;
  assign clr_evt = esr_rd | cls;

  // ------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------
  always_comb begin
    set_v = 16'h0000;
    set_v[BIT_OPC] = opc_fire;
    set_v[BIT_REQ_CTRL] = i_req_ctrl;
    set_v[BIT_QRY_ERR] = i_qry_err;
    set_v[BIT_DEV_ERR] = i_dev_err;
    set_v[BIT_EXE_ERR] = i_exe_err | (ese_wr & ese_bad);
    set_v[BIT_CMD_ERR] = i_cmd_err;
  end

  // ------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------
  always_comb begin
    evt_d = (clr_evt ? 16'h0000 : evt_q) | set_v;
    evt_d[RSVD_HI:RSVD_LO] = 8'h00;
    evt_d[BIT_USER_REQ] = 1'b0;
    ese_d = ese_q;
    rerr_d = 1'b0;
    ecode_d = ecode_q;
    if (ese_wr) begin
      if (ese_bad) begin
        rerr_d = 1'b1;
        ecode_d = ERR_DATA_RANGE;
      end else begin
        ese_d = i_cmd_arg[7:0];
      end
    end
    // An armed request is cancelled by clear status
    opc_arm_d = opc_arm_q;
    if (opc_fire | cls) begin
      opc_arm_d = 1'b0;
    end
    if (opc_cmd) begin
      opc_arm_d = 1'b1;
    end
    // summary to status byte bit 5
    sum_d = |(evt_d[7:0] & ese_d);
    ready_d = ~fmt_busy & ~fmt_start;
  end

  // Registers only; power on bit comes up set with reset
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      evt_q <= EVT_RST;
      ese_q <= ESE_RST;
      opc_arm_q <= 1'b0;
      ready_q <= 1'b0;
      sum_q <= 1'b0;
      rerr_q <= 1'b0;
      ecode_q <= ERR_NONE;
    end else begin
      evt_q <= evt_d;
      ese_q <= ese_d;
      opc_arm_q <= opc_arm_d;
      ready_q <= ready_d;
      sum_q <= sum_d;
      rerr_q <= rerr_d;
      ecode_q <= ecode_d;
    end
  end

  // ------------------------------------------------------------
  // Response path
  // ------------------------------------------------------------
  // value snapshot before the clear
  assign fmt_start = esr_rd | ese_rd;
  assign fmt_value = esr_rd ? evt_q[7:0] : ese_q;

  sesg_dec_fmt u_fmt (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_start(fmt_start),
    .i_value(fmt_value),
    .i_ready(i_resp_ready),
    .o_valid(o_resp_valid),
    .o_char(o_resp_char),
    .o_last(o_resp_last),
    .o_busy(fmt_busy)
  );

  assign o_cmd_ready = ready_q;
  assign o_event = evt_q;
  assign o_ese_mask = ese_q;
  assign o_esb_summary = sum_q;
  assign o_range_err = rerr_q;
  assign o_err_code = ecode_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  AST_RSVD_ZERO: assert property (evt_q[15:8] == 8'h00)
    else $error("Reserved event bits not zero");
  AST_USER_REQ: assert property (!evt_q[BIT_USER_REQ])
    else $error("User request bit set");
  AST_CMD_ERR: assert property (i_cmd_err |=> evt_q[BIT_CMD_ERR])
    else $error("Command error not latched");
  AST_EXE_ERR: assert property (
    (i_exe_err | (ese_wr & ese_bad)) |=> evt_q[BIT_EXE_ERR])
    else $error("Execution error not latched");
  AST_DEV_ERR: assert property (i_dev_err |=> evt_q[BIT_DEV_ERR])
    else $error("Device error not latched");
  AST_QRY_ERR: assert property (i_qry_err |=> evt_q[BIT_QRY_ERR])
    else $error("Query error not latched");
  AST_REQ_CTRL: assert property (i_req_ctrl |=> evt_q[1])
    else $error("Request control not shown");
  AST_OPC_ONLY: assert property (
    $rose(evt_q[BIT_OPC]) |-> $past(opc_arm_q) && $past(i_ops_idle))
    else $error("Operation complete without request");
  AST_RESP_START: assert property (
    esr_rd |=> o_resp_valid && !o_cmd_ready)
    else $error("Event query gave no response");
  AST_READ_CLR: assert property (
    (esr_rd && set_v == 16'h0000) |=> evt_q == 16'h0000)
    else $error("Event query did not clear");
  AST_CLS_CLR: assert property (
    (cls && set_v == 16'h0000) |=> evt_q == 16'h0000)
    else $error("Clear status did not clear");
  AST_SUMMARY: assert property (
    o_esb_summary == |(evt_q[7:0] & ese_q))
    else $error("Summary bit disagrees with mask");
  AST_RANGE: assert property (
    (ese_wr && ese_bad) |=> o_range_err && $stable(ese_q)
      && o_err_code == ERR_DATA_RANGE
      ##1 (!o_range_err || $past(ese_wr && ese_bad)))
    else $error("Bad mask value not refused");
  AST_STICKY: assert property (
    (evt_q[BIT_DEV_ERR] && !clr_evt) |=> evt_q[BIT_DEV_ERR])
    else $error("Latched event bit dropped");

endmodule

//--- tb/sesg_ctrl_model.sv
// Bus controller model: sends common commands, reads replies
`timescale 1ns/1ps
module sesg_ctrl_model
  import sesg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_cmd_ready,
  input wire logic i_resp_valid,
  input wire logic [7:0] i_resp_char,
  input wire logic i_resp_last,
  output logic o_cmd_valid,
  output sesg_cmd_e o_cmd,
  output logic signed [15:0] o_cmd_arg,
  output logic o_resp_ready
);
  logic slow = 1'b0;
  int acc = 0;
  int value = -1;
  int n_resp = 0;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = CMD_NONE;
    o_cmd_arg = 16'sh0000;
    o_resp_ready = 1'b1;
  end
  // Request held until taken; released lines show inverted junk
  task automatic send(input sesg_cmd_e c, input logic signed [15:0] a);
    @(negedge i_mclk);
    o_cmd_valid = 1'b1;
    o_cmd = c;
    o_cmd_arg = a;
    @(posedge i_mclk);
    while (i_cmd_ready !== 1'b1) @(posedge i_mclk);
    @(negedge i_mclk);
    o_cmd_valid = 1'b0;
    o_cmd = sesg_cmd_e'(~c);
    o_cmd_arg = ~a;
  endtask
  // Slow mode drops ready every other cycle to stress the hold
  always @(negedge i_mclk) begin
    o_resp_ready <= slow ? ~o_resp_ready : 1'b1;
  end
  always @(posedge i_mclk) begin
    if (i_resp_valid === 1'b1 && o_resp_ready) begin
      if (i_resp_last === 1'b1) begin
        value = acc;
        acc = 0;
        n_resp++;
      end else begin
        acc = acc * 10 + int'(i_resp_char - ASCII_ZERO);
      end
    end
  end
endmodule

//--- tb/sesg_top_tb.sv
// Self-checking bench of the standard event status group
`timescale 1ns/1ps
module sesg_top_tb;
  import sesg_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic [4:0] ev = 5'h00;
  logic i_ops_idle = 1'b0;
  logic cmd_valid, resp_ready, cmd_ready, resp_valid, resp_last;
  logic esb, range_err;
  sesg_cmd_e cmd;
  logic signed [15:0] arg, err_code;
  logic [7:0] resp_char, ese_mask;
  logic [15:0] o_event;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  // Rows: expected reply, then {cmd, exe, dev, qry, req} events
  logic [12:0] rows [8] = '{{8'd128, 5'h00}, {8'd32, 5'h10},
    {8'd16, 5'h08}, {8'd8, 5'h04}, {8'd4, 5'h02}, {8'd2, 5'h01},
    {8'd62, 5'h1F}, {8'd0, 5'h00}};
  always #25 i_mclk = ~i_mclk;
  sesg_top DUT (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_cmd_arg(arg),
    .i_cmd_err(ev[4]), .i_exe_err(ev[3]), .i_dev_err(ev[2]),
    .i_qry_err(ev[1]), .i_req_ctrl(ev[0]), .i_ops_idle(i_ops_idle),
    .i_resp_ready(resp_ready), .o_cmd_ready(cmd_ready),
    .o_resp_valid(resp_valid), .o_resp_char(resp_char),
    .o_resp_last(resp_last), .o_event(o_event), .o_ese_mask(ese_mask),
    .o_esb_summary(esb), .o_range_err(range_err), .o_err_code(err_code));
  sesg_ctrl_model CTRL (.i_mclk(i_mclk), .i_cmd_ready(cmd_ready),
    .i_resp_valid(resp_valid), .i_resp_char(resp_char),
    .i_resp_last(resp_last), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
    .o_cmd_arg(arg), .o_resp_ready(resp_ready));
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  // Events held three cycles: the repeat must not disturb the latch
  task automatic pulse(input logic [4:0] e);
    @(negedge i_mclk);
    ev = e;
    repeat (3) @(negedge i_mclk);
    ev = 5'h00;
    repeat (2) @(negedge i_mclk);
  endtask
  task automatic query(input sesg_cmd_e c, input int exp);
    int n;
    int t;
    n = CTRL.n_resp;
    CTRL.send(c, 16'sh0000);
    t = 0;
    while (CTRL.n_resp == n && t < 60) begin
      @(negedge i_mclk);
      t++;
    end
    // A missing reply must fail even if the stale value happens to match
    check(CTRL.n_resp != n && CTRL.value == exp, "query reply");
  endtask
  // Hang guard, far above the roughly 150 cycles needed
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(negedge i_mclk);
    check(o_event === EVT_RST && cmd_ready === 1'b0, "reset");
    i_reset = 1'b0;
    for (int i = 0; i < 8; i++) begin
      pulse(rows[i][4:0]);
      query(CMD_ESR_Q, int'(rows[i][12:5]));
      check(o_event === 16'h0000, "clear on read");
    end
    CTRL.send(CMD_OPC, 16'sh0000);
    repeat (4) @(negedge i_mclk);
    check(o_event[0] === 1'b0, "early complete");
    i_ops_idle = 1'b1;
    repeat (3) @(negedge i_mclk);
    query(CMD_ESR_Q, 1);
    CTRL.send(CMD_ESE_W, 16'sh0024);
    check(ese_mask === 8'h24 && esb === 1'b0, "mask write");
    CTRL.slow = 1'b1;
    query(CMD_ESE_Q, 36);
    CTRL.slow = 1'b0;
    pulse(5'h10);
    check(esb === 1'b1, "summary");
    CTRL.send(CMD_CLS, 16'sh0000);
    check(o_event === 16'h0 && esb === 1'b0, "clear");
    foreach (rows[k]) if (k < 2) begin
      CTRL.send(CMD_ESE_W, k == 0 ? -16'sd1 : 16'sh0100);
      check(range_err === 1'b1 && ese_mask === 8'h24, "refuse");
      check(err_code === ERR_DATA_RANGE, "code");
    end
    query(CMD_ESR_Q, 16);
    @(negedge i_mclk);
    i_reset = 1'b1;
    @(negedge i_mclk);
    check(o_event === EVT_RST && ese_mask === 8'h00, "reset");
    check(err_code === ERR_NONE && range_err === 1'b0, "rst code");
    i_reset = 1'b0;
    query(CMD_ESR_Q, 128);
    conclude();
  end
endmodule
